/* hdl/msu_avg.sv */
`timescale 1ns/100ps
`default_nettype none
module msu_avg #(
   parameter int SW = 16,
   parameter int CW = 16,
   parameter int SUBS = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic smp_valid,
   input wire logic [SW-1:0] smp,
   input wire msu_pkg::msu_window_t window,
   input wire msu_pkg::msu_start_t start_mode,
   input wire logic [CW-1:0] duration,
   input wire logic start_source,
   input wire logic clear_source,
   input wire logic clear_cmd,
   output logic [SW-1:0] avg,
   output logic [SW-1:0] peak
);
   import msu_pkg::*;
   localparam int SLW = (SUBS > 1) ? $clog2(SUBS) : 1;
   localparam int FW = $clog2(SUBS + 1);
   localparam int AW = SW + CW + FW;
   localparam int BW = $clog2(AW + 1);

   logic start_q_r, clear_q_r, armed_r;
   logic [AW-1:0] acc_r, total_r, num_r, den_r, rem_r;
   logic [AW-1:0] ring_r [SUBS];
   logic [CW-1:0] cnt_r;
   logic [SLW-1:0] slot_r;
   logic [FW-1:0] fill_r;
   logic [BW-1:0] bit_r;
   logic [SW-1:0] avg_r, peak_r;
   msu_div_state_t st_r;

   // ****************************************************************
   // Period bookkeeping
   // ****************************************************************
   // Rising edges of the start and clear sources; the direct command clears at once.
   wire start_rise = start_source & ~start_q_r; // [RULE13] [RULE18]
   wire clear_hit = clear_cmd | (clear_source & ~clear_q_r); // [RULE14] [RULE15]
   wire by_sig = (start_mode == MSU_START_SIGNAL); // [RULE12]
   wire slide = (window == MSU_WIN_SLIDING); // [RULE10]
   wire [AW-1:0] acc_add = acc_r + AW'(smp);
   wire [CW-1:0] cnt_inc = cnt_r + CW'(1);
   wire sub_end = smp_valid & ~by_sig & (cnt_inc == duration); // [RULE12]
   wire last_sub = (slot_r == SLW'(SUBS - 1));
   // Sliding drops the oldest sub-period from the running total. [RULE19]
   wire [AW-1:0] total_nxt = slide ? total_r - ring_r[slot_r] + acc_add : total_r + acc_add;
   wire [FW-1:0] fill_nxt = (fill_r == FW'(SUBS)) ? fill_r : fill_r + FW'(1);
   wire [AW-1:0] den_prod = AW'(fill_nxt) * AW'(duration);
   wire go = (sub_end & (slide | last_sub)) | (start_rise & by_sig & armed_r & (cnt_r != '0));
   wire [AW-1:0] go_num = by_sig ? acc_r : total_nxt;
   wire [AW-1:0] go_den = by_sig ? AW'(cnt_r) : den_prod;

   // Serial restoring divider, one quotient bit a cycle.
   wire [AW-1:0] rem_sh = {rem_r[AW-2:0], num_r[AW-1]};
   wire rem_ge = rem_sh >= den_r;
   wire [AW-1:0] num_sh = {num_r[AW-2:0], rem_ge};
   wire div_done = (st_r == MSU_DIV_RUN) && (bit_r == BW'(1));

   // Edge detector history.
   always_ff @(posedge clk) begin
      if (srst) begin
         start_q_r <= 1'h0;
         clear_q_r <= 1'h0;
      end else begin
         start_q_r <= start_source;
         clear_q_r <= clear_source;
      end
   end

   // Accumulation over sub-periods, whole periods or signal intervals.
   always_ff @(posedge clk) begin
      if (srst | clear_hit) begin
         armed_r <= 1'h0;
         acc_r <= '0;
         cnt_r <= '0;
         total_r <= '0;
         slot_r <= '0;
         fill_r <= '0;
         for (int i = 0; i < SUBS; i++) ring_r[i] <= '0;
      end else if (by_sig) begin
         if (start_rise) begin // [RULE13]
            armed_r <= 1'h1;
            acc_r <= smp_valid ? AW'(smp) : '0;
            cnt_r <= smp_valid ? CW'(1) : '0;
         end else if (smp_valid) begin
            acc_r <= acc_add;
            cnt_r <= cnt_inc;
         end
      end else if (sub_end) begin
         acc_r <= '0;
         cnt_r <= '0;
         ring_r[slot_r] <= acc_add; // [RULE19]
         slot_r <= last_sub ? '0 : slot_r + SLW'(1);
         if (!slide && last_sub) begin // [RULE11]
            total_r <= '0;
            fill_r <= '0;
         end else begin
            total_r <= total_nxt;
            fill_r <= fill_nxt;
         end
      end else if (smp_valid) begin
         acc_r <= acc_add;
         cnt_r <= cnt_inc;
      end
   end

   // Divider and result registers; a period end while busy is dropped.
   always_ff @(posedge clk) begin
      if (srst | clear_hit) begin // [RULE14] [RULE15]
         st_r <= MSU_DIV_IDLE;
         num_r <= '0;
         den_r <= '0;
         rem_r <= '0;
         bit_r <= '0;
         avg_r <= '0;
         peak_r <= '0;
      end else begin
         case (st_r)
            MSU_DIV_IDLE: begin
               if (go) begin
                  num_r <= go_num;
                  den_r <= go_den;
                  rem_r <= '0;
                  bit_r <= BW'(AW);
                  st_r <= MSU_DIV_RUN;
               end
            end
            MSU_DIV_RUN: begin
               rem_r <= rem_ge ? rem_sh - den_r : rem_sh;
               num_r <= num_sh;
               bit_r <= bit_r - BW'(1);
               if (div_done) begin
                  avg_r <= num_sh[SW-1:0];
                  if (num_sh[SW-1:0] > peak_r) peak_r <= num_sh[SW-1:0]; // [RULE16]
                  st_r <= MSU_DIV_IDLE;
               end
            end
            default: st_r <= MSU_DIV_IDLE;
         endcase
      end
   end

   assign avg = avg_r;
   assign peak = peak_r;

   a_avg_clear_zero: assert property (@(posedge clk) disable iff (srst) // [RULE14]
      clear_hit |=> (avg_r == '0) && (peak_r == '0)) else $error("Demand clear left values.");
   a_peak_over_avg: assert property (@(posedge clk) disable iff (srst) // [RULE16]
      peak_r >= avg_r) else $error("Peak below average.");
   a_fixed_fresh_start: assert property (@(posedge clk) disable iff (srst) // [RULE11]
      sub_end && !slide && last_sub && !clear_hit |=> total_r == '0 && fill_r == '0)
      else $error("Fixed period did not restart.");
   a_signal_interval: assert property (@(posedge clk) disable iff (srst) // [RULE13]
      by_sig && start_rise && !clear_hit |=> armed_r && cnt_r <= CW'(1))
      else $error("Signal edge did not open an interval.");
endmodule : msu_avg
`default_nettype wire

/* hdl/msu_pkg.sv */
`default_nettype none
package msu_pkg;
   // ****************************************************************
   // Energy counters
   // ****************************************************************
   // Counter width and the largest displayable count, 999 999.99 held in hundredths.
   localparam int ENERGY_W = 27;
   localparam logic [26:0] ENERGY_MAX = 27'h5F5E0FF;
   localparam logic [26:0] ENERGY_RST = 27'h0000000;
   // Active, reactive and apparent energy.
   localparam int NUM_EN = 3;

   // ****************************************************************
   // Measured quantities and reference channels
   // ****************************************************************
   // Quantity slots: current, voltage, power.
   localparam int NUM_QTY = 3;
   localparam int QTY_CUR = 0;
   localparam int QTY_VOLT = 1;
   localparam int QTY_POW = 2;
   // Voltage channels come first in the reference search, then three phases per current card.
   localparam int NUM_VOLT = 3;
   localparam int PH_PER_CARD = 3;
   localparam int REF_RST = 0;

   // ****************************************************************
   // Setting encodings
   // ****************************************************************
   typedef enum logic [1:0] {
      MSU_UNIT_AUTO = 2'h0,
      MSU_UNIT_KILO = 2'h1,
      MSU_UNIT_MEGA = 2'h2,
      MSU_UNIT_GIGA = 2'h3
   } msu_unit_t;
   typedef enum logic {
      MSU_WIN_SLIDING = 1'h0,
      MSU_WIN_FIXED = 1'h1
   } msu_window_t;
   typedef enum logic {
      MSU_START_DURATION = 1'h0,
      MSU_START_SIGNAL = 1'h1
   } msu_start_t;
   typedef enum logic {
      MSU_DIV_IDLE = 1'h0,
      MSU_DIV_RUN = 1'h1
   } msu_div_state_t;
endpackage : msu_pkg
`default_nettype wire

/* hdl/msu_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [RULE1] An energy counter past its top restarts from zero, never saturates.
// [RULE2] Each energy wrap raises that counter's overflow pulse.
// [RULE3] Unit is auto or fixed k/M/G; fixed wraps at 999 999.99, auto at given limit.
// [RULE4] Display values below the cutoff show zero; recorded values stay untouched.
// [RULE5] Reference is the first healthy voltage channel, tried in order.
// [RULE6] Without healthy voltages, currents phase 1, 2, 3 per card, card by card.
// [RULE7] The reference has angle zero; others are relative to it.
// [RULE8] Min/max restart on clear, device reset and configuration change.
// [RULE9] Separate clear sources wipe all minima or all maxima on rising edges.
// [RULE10] Averagers offer a sliding window over the most recent period.
// [RULE11] Fixed window clears its accumulation at each period end.
// [RULE12] Duration start uses per-channel duration with sliding or fixed window.
// [RULE13] Signal start averages between two consecutive rising edges.
// [RULE14] Direct clear command wipes a channel's average and peak at once.
// [RULE15] A channel's clear source wipes its values on its rising edge.
// [RULE16] Current and power channels keep peaks with independent settings.
// [RULE17] Voltage channel has its own window, start, duration and clear settings.
// [RULE18] Start and clear sources hold each level at least one clock.
// [RULE19] Sliding window is a ring of sub-period sums spanning the duration; here each sub-period lasts the duration, so the ring spans SUBS of them.
module msu_top #(
   parameter int SW = 16,
   parameter int IW = 16,
   parameter int AGW = 16,
   parameter int NCARD = 2,
   parameter int CW = 16,
   parameter int SUBS = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic smp_valid,
   input wire logic [msu_pkg::NUM_QTY*SW-1:0] meas,
   input wire logic [msu_pkg::NUM_QTY*SW-1:0] cutoff,
   output logic [msu_pkg::NUM_QTY*SW-1:0] meas_disp,
   input wire logic cfg_change,
   input wire logic minimum_clear_source,
   input wire logic maximum_clear_source,
   output logic [msu_pkg::NUM_QTY*SW-1:0] meas_min,
   output logic [msu_pkg::NUM_QTY*SW-1:0] meas_max,
   output logic [msu_pkg::NUM_QTY-1:0] min_valid,
   output logic [msu_pkg::NUM_QTY-1:0] max_valid,
   input wire logic energy_valid,
   input wire logic [msu_pkg::NUM_EN*IW-1:0] energy_inc,
   input wire msu_pkg::msu_unit_t energy_unit,
   input wire logic [msu_pkg::ENERGY_W-1:0] energy_auto_limit,
   output logic [msu_pkg::NUM_EN*msu_pkg::ENERGY_W-1:0] energy_count,
   output logic [msu_pkg::NUM_EN-1:0] energy_overflow,
   input wire logic voltage_meas_present,
   input wire logic [SW-1:0] ref_threshold,
   input wire logic [msu_pkg::NUM_VOLT*SW-1:0] volt_amp,
   input wire logic [msu_pkg::PH_PER_CARD*NCARD*SW-1:0] cur_amp,
   input wire logic [(msu_pkg::NUM_VOLT+msu_pkg::PH_PER_CARD*NCARD)*AGW-1:0] phase_abs,
   output logic [(msu_pkg::NUM_VOLT+msu_pkg::PH_PER_CARD*NCARD)*AGW-1:0] phase_rel,
   output logic [$clog2(msu_pkg::NUM_VOLT+msu_pkg::PH_PER_CARD*NCARD)-1:0] ref_index,
   output logic ref_valid,
   input wire msu_pkg::msu_window_t current_avg_window,
   input wire msu_pkg::msu_start_t current_avg_start_mode,
   input wire logic [CW-1:0] current_avg_duration,
   input wire logic current_avg_start_source,
   input wire logic current_avg_clear_source,
   input wire logic current_avg_clear_cmd,
   output logic [SW-1:0] current_avg,
   output logic [SW-1:0] current_peak,
   input wire msu_pkg::msu_window_t voltage_avg_window,
   input wire msu_pkg::msu_start_t voltage_avg_start_mode,
   input wire logic [CW-1:0] voltage_avg_duration,
   input wire logic voltage_avg_start_source,
   input wire logic voltage_avg_clear_source,
   input wire logic voltage_avg_clear_cmd,
   output logic [SW-1:0] voltage_avg,
   input wire msu_pkg::msu_window_t power_avg_window,
   input wire msu_pkg::msu_start_t power_avg_start_mode,
   input wire logic [CW-1:0] power_avg_duration,
   input wire logic power_avg_start_source,
   input wire logic power_avg_clear_source,
   input wire logic power_avg_clear_cmd,
   output logic [SW-1:0] power_avg,
   output logic [SW-1:0] power_peak
);
   import msu_pkg::*;
   localparam int NCH = NUM_VOLT + PH_PER_CARD * NCARD;
   localparam int RIW = $clog2(NCH);

   // ****************************************************************
   // Energy counters
   // ****************************************************************
   // Fixed prefixes wrap at the display maximum, automatic scaling at the supplied limit.
   wire [ENERGY_W-1:0] en_lim = (energy_unit == MSU_UNIT_AUTO) ? energy_auto_limit
                                                              : ENERGY_MAX; // [RULE3]

   for (genvar g = 0; g < NUM_EN; g++) begin : g_en
      logic [ENERGY_W-1:0] cnt_r;
      logic ovf_r;
      // The carry past the limit is kept, so counting resumes from zero.
      wire [ENERGY_W:0] sum = {1'h0, cnt_r} + (ENERGY_W + 1)'(energy_inc[g*IW +: IW]);
      wire wrap = sum > {1'h0, en_lim};
      wire [ENERGY_W:0] wrapped = sum - {1'h0, en_lim} - (ENERGY_W + 1)'(1);

      // Counter update and one-cycle overflow pulse.
      always_ff @(posedge clk) begin
         if (srst) begin
            cnt_r <= ENERGY_RST;
            ovf_r <= 1'h0;
         end else begin
            ovf_r <= energy_valid & wrap; // [RULE2]
            if (energy_valid) begin
               cnt_r <= wrap ? wrapped[ENERGY_W-1:0] : sum[ENERGY_W-1:0]; // [RULE1]
            end
         end
      end

      assign energy_count[g*ENERGY_W +: ENERGY_W] = cnt_r;
      assign energy_overflow[g] = ovf_r;

      a_energy_wrap_flag: assert property (@(posedge clk) disable iff (srst) // [RULE2]
         energy_valid && wrap |=> ovf_r && cnt_r < $past(sum[ENERGY_W-1:0]))
         else $error("Energy wrap without overflow pulse.");
      a_energy_fixed_top: assert property (@(posedge clk) disable iff (srst) // [RULE3]
         energy_valid && energy_unit != MSU_UNIT_AUTO && !wrap |=> cnt_r <= ENERGY_MAX)
         else $error("Energy counter above display maximum.");
   end

   // ****************************************************************
   // Cutoff display and minimum / maximum tracking
   // ****************************************************************
   logic minc_q_r, maxc_q_r;
   // Clear sources act on their rising edge, one clock after a held level.
   wire min_rise = minimum_clear_source & ~minc_q_r; // [RULE9] [RULE18]
   wire max_rise = maximum_clear_source & ~maxc_q_r; // [RULE9] [RULE18]
   wire min_restart = cfg_change | min_rise; // [RULE8]
   wire max_restart = cfg_change | max_rise; // [RULE8]

   // Edge detector history for the two clear sources.
   always_ff @(posedge clk) begin
      if (srst) begin
         minc_q_r <= 1'h0;
         maxc_q_r <= 1'h0;
      end else begin
         minc_q_r <= minimum_clear_source;
         maxc_q_r <= maximum_clear_source;
      end
   end

   for (genvar q = 0; q < NUM_QTY; q++) begin : g_qty
      logic [SW-1:0] disp_r, min_r, max_r;
      logic minv_r, maxv_r;
      wire [SW-1:0] x = meas[q*SW +: SW];
      wire below = x < cutoff[q*SW +: SW];

      // Display copy only; min, max and demand always see the raw sample.
      always_ff @(posedge clk) begin
         if (srst) begin
            disp_r <= '0;
         end else if (smp_valid) begin
            disp_r <= below ? '0 : x; // [RULE4]
         end
      end

      // Restart wins over a sample arriving in the same cycle.
      always_ff @(posedge clk) begin
         if (srst || min_restart) begin // [RULE8] [RULE9]
            min_r <= '0;
            minv_r <= 1'h0;
         end else if (smp_valid && (!minv_r || x < min_r)) begin
            min_r <= x;
            minv_r <= 1'h1;
         end
      end

      // Maximum tracker, mirror of the minimum.
      always_ff @(posedge clk) begin
         if (srst || max_restart) begin // [RULE8] [RULE9]
            max_r <= '0;
            maxv_r <= 1'h0;
         end else if (smp_valid && (!maxv_r || x > max_r)) begin
            max_r <= x;
            maxv_r <= 1'h1;
         end
      end

      assign meas_disp[q*SW +: SW] = disp_r;
      assign meas_min[q*SW +: SW] = min_r;
      assign meas_max[q*SW +: SW] = max_r;
      assign min_valid[q] = minv_r;
      assign max_valid[q] = maxv_r;

      a_cutoff_zero: assert property (@(posedge clk) disable iff (srst) // [RULE4]
         smp_valid && below |=> disp_r == '0 ##0 meas_min[q*SW +: SW] <= $past(x))
         else $error("Cutoff did not blank the display.");
      a_min_clear_edge: assert property (@(posedge clk) disable iff (srst) // [RULE9]
         $rose(minimum_clear_source) |=> !minv_r && min_r == '0)
         else $error("Minimum not cleared on rising edge.");
      a_cfg_restart: assert property (@(posedge clk) disable iff (srst) // [RULE8]
         cfg_change |=> !minv_r && !maxv_r) else $error("Min/max not restarted.");
   end

   // ****************************************************************
   // Phase reference selection
   // ****************************************************************
   // Channel order: voltages first, then currents card by card, phase 1 to 3.
   wire [NCH*SW-1:0] all_amp = {cur_amp, volt_amp};
   wire [NCH-1:0] healthy;
   logic [RIW-1:0] ref_sel;
   logic ref_ok;
   logic [RIW-1:0] ref_r;
   logic refv_r;
   logic [NCH*AGW-1:0] rel_r;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      // Voltage channels count only when voltage is really measured.
      assign healthy[c] = (all_amp[c*SW +: SW] >= ref_threshold)
                          && (c >= NUM_VOLT || voltage_meas_present); // [RULE5] [RULE6]
   end

   // Lowest healthy channel wins; with none, the previous reference is held.
   always_comb begin
      ref_sel = ref_r;
      ref_ok = 1'h0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (healthy[i]) begin // [RULE5] [RULE6]
            ref_sel = RIW'(i);
            ref_ok = 1'h1;
         end
      end
   end

   wire [AGW-1:0] ref_ang = phase_abs[ref_sel*AGW +: AGW];

   // Angles wrap modulo a full turn, so the reference itself lands on zero.
   always_ff @(posedge clk) begin
      if (srst) begin
         ref_r <= RIW'(REF_RST);
         refv_r <= 1'h0;
         rel_r <= '0;
      end else if (smp_valid) begin
         ref_r <= ref_sel;
         refv_r <= ref_ok;
         for (int i = 0; i < NCH; i++) begin
            rel_r[i*AGW +: AGW] <= phase_abs[i*AGW +: AGW] - ref_ang; // [RULE7]
         end
      end
   end

   assign ref_index = ref_r;
   assign ref_valid = refv_r;
   assign phase_rel = rel_r;

   a_ref_volt_first: assert property (@(posedge clk) disable iff (srst) // [RULE5]
      smp_valid && voltage_meas_present && volt_amp[SW-1:0] >= ref_threshold
      |=> ref_r == '0 && refv_r) else $error("First voltage not chosen.");
   a_ref_current: assert property (@(posedge clk) disable iff (srst) // [RULE6]
      smp_valid && !voltage_meas_present && cur_amp[SW-1:0] >= ref_threshold
      |=> ref_r == RIW'(NUM_VOLT)) else $error("First current not chosen.");
   a_ref_angle_zero: assert property (@(posedge clk) disable iff (srst) // [RULE7]
      $past(smp_valid) |-> rel_r[ref_r*AGW +: AGW] == '0) else $error("Reference angle not zero.");

   // ****************************************************************
   // Demand averagers
   // ****************************************************************
   // Current demand with its own window, start, duration and clear settings.
   msu_avg #(.SW(SW), .CW(CW), .SUBS(SUBS)) u_cur_avg ( // [RULE16]
      .clk(clk),
      .srst(srst),
      .smp_valid(smp_valid),
      .smp(meas[QTY_CUR*SW +: SW]),
      .window(current_avg_window),
      .start_mode(current_avg_start_mode),
      .duration(current_avg_duration),
      .start_source(current_avg_start_source),
      .clear_source(current_avg_clear_source),
      .clear_cmd(current_avg_clear_cmd),
      .avg(current_avg),
      .peak(current_peak)
   );

   // Voltage average, fully independent of the demand channels; no peak is kept.
   msu_avg #(.SW(SW), .CW(CW), .SUBS(SUBS)) u_volt_avg ( // [RULE17]
      .clk(clk),
      .srst(srst),
      .smp_valid(smp_valid),
      .smp(meas[QTY_VOLT*SW +: SW]),
      .window(voltage_avg_window),
      .start_mode(voltage_avg_start_mode),
      .duration(voltage_avg_duration),
      .start_source(voltage_avg_start_source),
      .clear_source(voltage_avg_clear_source),
      .clear_cmd(voltage_avg_clear_cmd),
      .avg(voltage_avg),
      .peak()
   );

   // Power demand with its own settings and peak.
   msu_avg #(.SW(SW), .CW(CW), .SUBS(SUBS)) u_pow_avg ( // [RULE16]
      .clk(clk),
      .srst(srst),
      .smp_valid(smp_valid),
      .smp(meas[QTY_POW*SW +: SW]),
      .window(power_avg_window),
      .start_mode(power_avg_start_mode),
      .duration(power_avg_duration),
      .start_source(power_avg_start_source),
      .clear_source(power_avg_clear_source),
      .clear_cmd(power_avg_clear_cmd),
      .avg(power_avg),
      .peak(power_peak)
   );
endmodule : msu_top
`default_nettype wire

/* tb/msu_front_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Front end: one strobe per sample, the same value in every slot.
module msu_front_model (
   input wire logic go,
   input wire logic [15:0] val,
   output logic smp_valid,
   output logic [msu_pkg::NUM_QTY*16-1:0] meas
);
   import msu_pkg::*;
   // Outside a strobe the bus shows the inverse, so stale data never matches.
   assign smp_valid = go;
   assign meas = go ? {NUM_QTY{val}} : {NUM_QTY{~val}};
endmodule : msu_front_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import msu_pkg::*;
   logic clk, srst, go, sv, cfg, mn, mx, ev, vp, ss, cs, cc;
   logic [15:0] v, cav, cpk, vav, pav, ppk;
   logic [47:0] ms, cut, disp, mno, mxo, va;
   logic [2:0] mnv, mxv, ovf;
   logic [80:0] cnt;
   logic [95:0] ca;
   logic [143:0] pa, pr;
   logic [3:0] ri;
   logic rv;
   msu_window_t w;
   msu_start_t sm;
   msu_unit_t eu;
   int errors, comparisons, n;
   msu_front_model i_msu_front_model (.go(go), .val(v), .smp_valid(sv), .meas(ms));
   msu_top i_msu_top (.clk(clk), .srst(srst), .smp_valid(sv), .meas(ms), .cutoff(cut),
      .meas_disp(disp), .cfg_change(cfg), .minimum_clear_source(mn),
      .maximum_clear_source(mx), .meas_min(mno), .meas_max(mxo), .min_valid(mnv),
      .max_valid(mxv), .energy_valid(ev), .energy_inc({3{16'h3C}}), .energy_unit(eu),
      .energy_auto_limit(27'h64), .energy_count(cnt), .energy_overflow(ovf),
      .voltage_meas_present(vp), .ref_threshold(16'h10), .volt_amp(va), .cur_amp(ca),
      .phase_abs(pa), .phase_rel(pr), .ref_index(ri), .ref_valid(rv),
      .current_avg_window(w), .current_avg_start_mode(sm), .current_avg_duration(16'h1),
      .current_avg_start_source(ss), .current_avg_clear_source(cs),
      .current_avg_clear_cmd(cc), .current_avg(cav), .current_peak(cpk),
      .voltage_avg_window(w), .voltage_avg_start_mode(sm), .voltage_avg_duration(16'h1),
      .voltage_avg_start_source(ss), .voltage_avg_clear_source(cs),
      .voltage_avg_clear_cmd(cc), .voltage_avg(vav), .power_avg_window(w),
      .power_avg_start_mode(sm), .power_avg_duration(16'h1), .power_avg_start_source(ss),
      .power_avg_clear_source(cs), .power_avg_clear_cmd(cc), .power_avg(pav),
      .power_peak(ppk));
   // Free-running 250 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Compares a seen value with the expected one and counts both outcomes.
   task chk(input logic [47:0] s, input logic [47:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   // Prints the counts and the verdict, then ends the run.
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   // One sample through the front end, then time for the answer to settle.
   task smp(input logic [15:0] x);
      @(posedge clk);
      v <= x;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
   endtask : smp
   // Drives one source level: 0 cfg, 1 min, 2 max, 3 cmd, 4 clear, else start.
   task drv(input int k, input logic b);
      case (k)
         0: cfg <= b;
         1: mn <= b;
         2: mx <= b;
         3: cc <= b;
         4: cs <= b;
         default: ss <= b;
      endcase
   endtask : drv
   // A level pulse of two cycles on a source, so its rising edge is seen.
   task pulse(input int k);
      @(posedge clk);
      drv(k, 1'b1);
      @(posedge clk);
      @(posedge clk);
      drv(k, 1'b0);
      #1;
   endtask : pulse
   // Two energy strobes back to back.
   task en2;
      @(posedge clk);
      ev <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      ev <= 1'b0;
      #1;
   endtask : en2
   // Samples, then a bounded wait for the current average to move.
   task dem(input logic [15:0] x, input int k, input logic [15:0] old);
      repeat (k) smp(x);
      for (n = 0; n < 100 && cav === old; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 100) begin
         errors++;
         wrap_up();
      end
   endtask : dem
   // Main sequence.
   initial begin
      {srst, go, cfg, mn, mx, ev, vp, ss, cs, cc} = 10'h201;
      v = 16'h0;
      cut = {3{16'h4}};
      va = {3{16'h20}};
      ca = {{5{16'h20}}, 16'h1};
      w = MSU_WIN_FIXED;
      sm = MSU_START_DURATION;
      eu = MSU_UNIT_AUTO;
      errors = 0;
      comparisons = 0;
      for (int i = 0; i < 9; i++) pa[i*16 +: 16] = 16'(i) * 16'h1000;
      vp = 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      pulse(0);
      chk(48'(mnv), 48'h0);
      smp(16'h3);
      chk(disp, 48'h0);
      chk(mno, {3{16'h3}});
      smp(16'h9);
      chk(disp, {3{16'h9}});
      pulse(1);
      chk(48'(mnv), 48'h0);
      chk(mxo, {3{16'h9}});
      pulse(2);
      chk(48'(mxv), 48'h0);
      $display("test min max done");
      en2();
      chk(48'(cnt[26:0]), 48'h13);
      chk(48'(cnt[80:54]), 48'h13);
      chk(48'(ovf), 48'h7);
      @(posedge clk);
      eu <= MSU_UNIT_KILO;
      #1;
      chk(48'(ovf), 48'h0);
      en2();
      chk(48'(cnt[26:0]), 48'h8B);
      $display("test energy done");
      @(posedge clk);
      va <= {16'h20, 16'h20, 16'h1};
      smp(16'h5);
      chk(48'(ri), 48'h1);
      chk(48'(pr[31:0]), 48'hF000);
      @(posedge clk);
      vp <= 1'b0;
      smp(16'h5);
      chk(48'(ri), 48'h4);
      chk(48'({pr[79:64], 15'h0, rv}), 48'h1);
      $display("test reference done");
      pulse(3);
      dem(16'h8, 4, 16'h0);
      chk(48'({cav, cpk, vav}), {3{16'h8}});
      chk(48'({pav, ppk}), {2{16'h8}});
      dem(16'h4, 4, 16'h8);
      chk(48'({cav, cpk, vav}), {16'h4, 16'h8, 16'h4});
      pulse(3);
      chk(48'({cav, cpk}), 48'h0);
      @(posedge clk);
      w <= MSU_WIN_SLIDING;
      dem(16'hC, 1, 16'h0);
      chk(48'({cav, vav}), {2{16'hC}});
      pulse(4);
      chk(48'({pav, ppk}), 48'h0);
      @(posedge clk);
      sm <= MSU_START_SIGNAL;
      pulse(5);
      repeat (2) smp(16'h6);
      pulse(5);
      dem(16'h6, 0, 16'h0);
      chk(48'({cav, vav}), {2{16'h6}});
      $display("test demand done");
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
